/* hw/tcps_top.sv */
// Summary of operation
// (R1) Prescale code 00, 01, 10 divides system clock by 12, 4, 48.
// (R2) Code 11 gives synchronised external clock divided by 8.
// (R3) Timer 1 select 0 uses prescaler, 1 uses system clock.
// (R4) Timer 1 counter mode makes its clock select irrelevant.
// (R5) Timer 0 select 0 uses prescaler, 1 uses system clock.
// (R6) Timer 0 counter mode makes its clock select ignored.
// (R7) Timer 2 low select: 0 external choice, 1 system clock.
// (R8) Timer 2 high select, split mode only, same choice as low.
// (R9) Control bits 7 and 6 read zero and ignore writes.
// (R10) Timer 0 low byte is read/write and resets to zero.
// (R11) Timer 1 low byte is read/write and resets to zero.
// (R12) A prescaler choice reaches a timer as one-cycle enable pulse; system clock as a constant enable.
`timescale 1ns/10ps
`default_nettype none
`include "tcps_defs.svh"
module tcps_top (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               ext_clk,
  input  wire logic               t0_event,
  input  wire logic               t1_event,
  input  wire logic               t2_ext_tick,
  input  wire logic               t0_inc,
  input  wire logic               t1_inc,
  output tcps_pkg::tcps_ticks_s   ticks,
  output logic [7:0]              t0_count_low,
  output logic [7:0]              t1_count_low
);

  //////////////////////////////////////////////////////////////////////////
  // Register storage and bus decode.
  logic [7:0]          ctrl_ff;
  logic [7:0]          mode_ff;
  logic [7:0]          t0lo_ff;
  logic [7:0]          t1lo_ff;
  logic [31:0]         prdata_ff;
  logic                wr_en;
  logic                rd_en;
  logic                hit;
  logic                ext_rise;
  logic                div_tick;
  logic                div_en;
  logic [5:0]          div_sel;
  logic [1:0]          code_q_ff;
  tcps_pkg::tcps_src_e src;
  logic                t2x_tick;
  logic                t0_tick;
  logic                t1_tick;
  logic                t2l_tick;
  logic                t2h_tick;

  // Maps an address to its decode hit.
  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `TCPS_ADDR_T0LO) || (a == `TCPS_ADDR_T1LO) ||
               (a == `TCPS_ADDR_CTRL) || (a == `TCPS_ADDR_MODE);
  endfunction

  // Zero-wait slave; unmapped addresses answer with an error.
  assign hit     = addr_hit(paddr);
  assign wr_en   = psel & penable & pwrite & hit;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_ff;

  // Control register; only the low six bits store.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `TCPS_RST_BYTE;
    end else if (wr_en && paddr == `TCPS_ADDR_CTRL) begin
      ctrl_ff <= pwdata[7:0] & `TCPS_CTRL_WMASK; // R9
    end
  end

  // Mode register: counter modes, Timer 2 external choice, split mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= `TCPS_RST_BYTE;
    end else if (wr_en && paddr == `TCPS_ADDR_MODE) begin
      mode_ff <= pwdata[7:0] & `TCPS_MODE_WMASK;
    end
  end

  // Timer 0 low byte; a software write wins over the count increment.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t0lo_ff <= `TCPS_RST_BYTE; // R10
    end else if (wr_en && paddr == `TCPS_ADDR_T0LO) begin
      t0lo_ff <= pwdata[7:0]; // R10
    end else if (t0_inc) begin
      t0lo_ff <= t0lo_ff + 8'h01;
    end
  end

  // Timer 1 low byte, same arrangement as Timer 0.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1lo_ff <= `TCPS_RST_BYTE; // R11
    end else if (wr_en && paddr == `TCPS_ADDR_T1LO) begin
      t1lo_ff <= pwdata[7:0]; // R11
    end else if (t1_inc) begin
      t1lo_ff <= t1lo_ff + 8'h01;
    end
  end

  // Read data is latched in the setup phase so it is a flop output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        `TCPS_ADDR_T0LO: prdata_ff <= {24'h00_0000, t0lo_ff};
        `TCPS_ADDR_T1LO: prdata_ff <= {24'h00_0000, t1lo_ff};
        `TCPS_ADDR_CTRL: prdata_ff <= {24'h00_0000, ctrl_ff};
        `TCPS_ADDR_MODE: prdata_ff <= {24'h00_0000, mode_ff};
        default:         prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign t0_count_low = t0lo_ff;
  assign t1_count_low = t1lo_ff;

  //////////////////////////////////////////////////////////////////////////
  // Shared prescaler.
  tcps_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (ext_clk),
    .rise    (ext_rise)
  );

  // Decode the prescale code into a one-hot source.
  always_comb begin
    case (ctrl_ff[1:0])
      `TCPS_CODE_DIV12: src = tcps_pkg::SRC_DIV12;
      `TCPS_CODE_DIV4:  src = tcps_pkg::SRC_DIV4;
      `TCPS_CODE_DIV48: src = tcps_pkg::SRC_DIV48;
      default:          src = tcps_pkg::SRC_EXT8;
    endcase
  end

  // One counter serves all codes; only its input and divisor change.
  always_comb begin
    case (src)
      tcps_pkg::SRC_DIV12: begin
        div_sel = `TCPS_DIV12; // R1
        div_en  = 1'b1;
      end
      tcps_pkg::SRC_DIV4: begin
        div_sel = `TCPS_DIV4; // R1
        div_en  = 1'b1;
      end
      tcps_pkg::SRC_DIV48: begin
        div_sel = `TCPS_DIV48; // R1
        div_en  = 1'b1;
      end
      tcps_pkg::SRC_EXT8: begin
        div_sel = `TCPS_DIV8; // R2
        div_en  = ext_rise; // R2
      end
      default: begin
        div_sel = `TCPS_DIV12;
        div_en  = 1'b1;
      end
    endcase
  end

  // Remember the code so a change restarts the count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_q_ff <= 2'b00;
    end else begin
      code_q_ff <= ctrl_ff[1:0];
    end
  end

  tcps_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (div_en),
    .clr     (code_q_ff != ctrl_ff[1:0]),
    .div     (div_sel),
    .tick    (div_tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // Per-timer selection as enables; system clock choices hold the enable high every cycle.
  assign t2x_tick = mode_ff[`TCPS_MODE_T2X] ? div_tick : t2_ext_tick;

  // Counter mode takes the event input and ignores the clock select.
  always_comb begin
    if (mode_ff[`TCPS_MODE_T0CNT]) begin
      t0_tick = t0_event; // R6
    end else if (ctrl_ff[`TCPS_CTRL_T0]) begin
      t0_tick = 1'b1; // R5 R12
    end else begin
      t0_tick = div_tick; // R5 R12
    end
  end

  always_comb begin
    if (mode_ff[`TCPS_MODE_T1CNT]) begin
      t1_tick = t1_event; // R4
    end else if (ctrl_ff[`TCPS_CTRL_T1]) begin
      t1_tick = 1'b1; // R3 R12
    end else begin
      t1_tick = div_tick; // R3 R12
    end
  end

  assign t2l_tick = ctrl_ff[`TCPS_CTRL_T2L] ? 1'b1 : t2x_tick; // R7
  // Outside split mode the high byte takes the low byte's enable unchanged.
  assign t2h_tick = ~mode_ff[`TCPS_MODE_SPLIT] ? t2l_tick :
                    (ctrl_ff[`TCPS_CTRL_T2H] ? 1'b1 : t2x_tick); // R8

  assign ticks.t0      = t0_tick;
  assign ticks.t1      = t1_tick;
  assign ticks.t2_low  = t2l_tick;
  assign ticks.t2_high = t2h_tick;

  //////////////////////////////////////////////////////////////////////////
  // Assertions.
  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn) ctrl_ff[7:6] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // R9
    else $error("reserved control bits not zero");

  // The code must already hold the cycle before the tick, since a code
  // change clears the counter and would shift the next tick by one.
  property p_div4;
    @(posedge pclk) disable iff (!presetn)
      (src == tcps_pkg::SRC_DIV4) ##1
      (src == tcps_pkg::SRC_DIV4 && div_tick) ##1
      (src == tcps_pkg::SRC_DIV4) [*4] |-> div_tick;
  endproperty
  a_div4: assert property (p_div4) // R1
    else $error("divide by four period wrong");

  property p_div12_gap;
    @(posedge pclk) disable iff (!presetn)
      (src == tcps_pkg::SRC_DIV12 && div_tick)
      |=> (src != tcps_pkg::SRC_DIV12 || !div_tick) [*8];
  endproperty
  a_div12_gap: assert property (p_div12_gap) // R1
    else $error("divide by twelve pulse too early");

  property p_ext_no_tick;
    @(posedge pclk) disable iff (!presetn)
      (src == tcps_pkg::SRC_EXT8 && $stable(ctrl_ff) && !div_en)
      |=> !div_tick;
  endproperty
  a_ext_no_tick: assert property (p_ext_no_tick) // R2
    else $error("external divide ticked without edge");

  property p_t0_sys;
    @(posedge pclk) disable iff (!presetn)
      (!mode_ff[`TCPS_MODE_T0CNT] && ctrl_ff[`TCPS_CTRL_T0]) |-> ticks.t0;
  endproperty
  a_t0_sys: assert property (p_t0_sys) // R5
    else $error("timer 0 not on system clock");

  property p_t0_pre;
    @(posedge pclk) disable iff (!presetn)
      (!mode_ff[`TCPS_MODE_T0CNT] && !ctrl_ff[`TCPS_CTRL_T0])
      |-> (ticks.t0 == div_tick);
  endproperty
  a_t0_pre: assert property (p_t0_pre) // R5
    else $error("timer 0 not on prescaler");

  property p_t0_cnt;
    @(posedge pclk) disable iff (!presetn)
      mode_ff[`TCPS_MODE_T0CNT] |-> (ticks.t0 == t0_event);
  endproperty
  a_t0_cnt: assert property (p_t0_cnt) // R6
    else $error("timer 0 counter mode not on event");

  property p_t1_cnt;
    @(posedge pclk) disable iff (!presetn)
      mode_ff[`TCPS_MODE_T1CNT] |-> (ticks.t1 == t1_event);
  endproperty
  a_t1_cnt: assert property (p_t1_cnt) // R4
    else $error("timer 1 counter mode not on event");

  property p_t1_sys;
    @(posedge pclk) disable iff (!presetn)
      (!mode_ff[`TCPS_MODE_T1CNT] && ctrl_ff[`TCPS_CTRL_T1]) |-> ticks.t1;
  endproperty
  a_t1_sys: assert property (p_t1_sys) // R3
    else $error("timer 1 not on system clock");

  property p_t2l;
    @(posedge pclk) disable iff (!presetn)
      (!ctrl_ff[`TCPS_CTRL_T2L] && !mode_ff[`TCPS_MODE_T2X])
      |-> (ticks.t2_low == t2_ext_tick);
  endproperty
  a_t2l: assert property (p_t2l) // R7
    else $error("timer 2 low source wrong");

  property p_t2h_split;
    @(posedge pclk) disable iff (!presetn)
      (mode_ff[`TCPS_MODE_SPLIT] && ctrl_ff[`TCPS_CTRL_T2H]) |-> ticks.t2_high;
  endproperty
  a_t2h_split: assert property (p_t2h_split) // R8
    else $error("timer 2 high not on system clock");

  property p_t2h_whole;
    @(posedge pclk) disable iff (!presetn)
      !mode_ff[`TCPS_MODE_SPLIT] |-> (ticks.t2_high == ticks.t2_low);
  endproperty
  a_t2h_whole: assert property (p_t2h_whole) // R8
    else $error("timer 2 high select used outside split mode");

  property p_t0lo_wr;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `TCPS_ADDR_T0LO) |=> t0lo_ff == $past(pwdata[7:0]);
  endproperty
  a_t0lo_wr: assert property (p_t0lo_wr) // R10
    else $error("timer 0 low byte write lost");

  property p_t1lo_wr;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `TCPS_ADDR_T1LO) |=> t1lo_ff == $past(pwdata[7:0]);
  endproperty
  a_t1lo_wr: assert property (p_t1lo_wr) // R11
    else $error("timer 1 low byte write lost");

  // Every divider output is a single-cycle enable, never a level.
  property p_tick_pulse;
    @(posedge pclk) disable iff (!presetn)
      div_tick |=> !div_tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) // R12
    else $error("divider tick held for two cycles");

  c_div48: cover property (@(posedge pclk) src == tcps_pkg::SRC_DIV48
    && div_tick);
  c_ext8: cover property (@(posedge pclk) src == tcps_pkg::SRC_EXT8
    && div_tick);
  c_split: cover property (@(posedge pclk) mode_ff[`TCPS_MODE_SPLIT]
    && ticks.t2_high);
  c_t1_counter: cover property (@(posedge pclk) mode_ff[`TCPS_MODE_T1CNT]
    && ticks.t1);
endmodule
`default_nettype wire

/* hw/tcps_defs.svh */
`ifndef TCPS_DEFS_SVH
`define TCPS_DEFS_SVH
// Register byte addresses (printed offsets are byte addresses).
`define TCPS_ADDR_T0LO   12'h08a
`define TCPS_ADDR_T1LO   12'h08b
`define TCPS_ADDR_CTRL   12'h08e
`define TCPS_ADDR_MODE   12'h090
// Control register fields.
`define TCPS_CTRL_T2H    5
`define TCPS_CTRL_T2L    4
`define TCPS_CTRL_T1     3
`define TCPS_CTRL_T0     2
`define TCPS_CTRL_WMASK  8'h3f
// Own mode register fields.
`define TCPS_MODE_T0CNT  0
`define TCPS_MODE_T1CNT  1
`define TCPS_MODE_T2X    2
`define TCPS_MODE_SPLIT  3
`define TCPS_MODE_WMASK  8'h0f
// Reset values.
`define TCPS_RST_BYTE    8'h00
// Prescale codes and divisors.
`define TCPS_CODE_DIV12  2'b00
`define TCPS_CODE_DIV4   2'b01
`define TCPS_CODE_DIV48  2'b10
`define TCPS_CODE_EXT8   2'b11
`define TCPS_DIV12       6'd12
`define TCPS_DIV4        6'd4
`define TCPS_DIV48       6'd48
`define TCPS_DIV8        6'd8
`endif

/* hw/tcps_pkg.sv */
package tcps_pkg;
  // Per-timer count-enable pulses leaving the block.
  typedef struct packed {
    logic t0;
    logic t1;
    logic t2_low;
    logic t2_high;
  } tcps_ticks_s;
  // Prescaler source selection.
  typedef enum logic [3:0] {
    SRC_DIV12 = 4'b0001,
    SRC_DIV4  = 4'b0010,
    SRC_DIV48 = 4'b0100,
    SRC_EXT8  = 4'b1000
  } tcps_src_e;
endpackage

/* hw/tcps_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// Two-stage synchroniser followed by a rising edge detector.
module tcps_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      rise
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // Only s2_ff and s3_ff feed the edge detector; s1_ff may be metastable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign rise = s2_ff & ~s3_ff;
endmodule
`default_nettype wire

/* hw/tcps_div.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tcps_defs.svh"
// Counts enable pulses and emits one pulse every div of them.
module tcps_div (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       en,
  input  wire logic       clr,
  input  wire logic [5:0] div,
  output logic            tick
);
  logic [5:0] cnt_ff;
  logic       tick_ff;

  // Clearing on a divisor change avoids one long stray period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= 6'h00;
      tick_ff <= 1'b0;
    end else if (clr) begin
      cnt_ff  <= 6'h00;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (en) begin
        if (cnt_ff == div - 6'd1) begin
          cnt_ff  <= 6'h00;
          tick_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 6'd1;
        end
      end
    end
  end

  assign tick = tick_ff;
endmodule
`default_nettype wire

/* tb/tcps_top_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tcps_defs.svh"
module tcps_top_test;
  logic                  pclk = 0;
  logic                  presetn = 0;
  logic                  psel = 0;
  logic                  penable = 0;
  logic                  pwrite = 0;
  logic [11:0]           paddr = 12'h000;
  logic [31:0]           pwdata = 32'h0000_0000;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  ext_clk = 0;
  logic                  evt = 0;
  logic                  t0_inc = 0;
  logic                  t1_inc = 0;
  tcps_pkg::tcps_ticks_s ticks;
  logic [3:0]            tk;
  logic [7:0]            t0_count_low;
  logic [7:0]            t1_count_low;
  logic [31:0]           exq[$];
  logic [11:0]           adq[$];
  logic [31:0]           d;
  int                    miscompares = 0;
  int                    n_compared = 0;
  int                    cyc = 0;

  tcps_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_clk(ext_clk),
    .t0_event(evt), .t1_event(evt), .t2_ext_tick(evt),
    .t0_inc(t0_inc), .t1_inc(t1_inc), .ticks(ticks),
    .t0_count_low(t0_count_low), .t1_count_low(t1_count_low)
  );
  assign tk = ticks;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, plus a slow external clock of six cycles and an event every five.
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    ext_clk <= (cyc % 6) < 3;
    evt <= (cyc % 5) == 0;
  end

  task automatic check(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic complete_run;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One APB transfer; a read notes its expected data for the monitor.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, input logic [31:0] e);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    if (!w) begin
      exq.push_back(e);
      adq.push_back(a);
    end
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 0;
    penable <= 0;
    if (n >= 50) begin
      miscompares++;
      complete_run;
    end
  endtask

  // Cycles between two pulses on one enable bit; the first pulse seen may
  // be left over from the previous setting, so two pulses are skipped.
  task automatic gap(input int b, input int e, input string nm);
    int n;
    repeat (3) begin
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while (tk[b] !== 1'b1 && n < 400);
    end
    check(nm, 32'(n), 32'(e));
    if (n >= 400)
      complete_run;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read monitor takes the oldest note once the access phase completes.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check("prdata", prdata, exq.pop_front());
      check("pslverr", {31'h0, pslverr}, {31'h0, adq.pop_front() == 12'h0a0});
    end
  end

  // Hard stop in case a wait somewhere never ends.
  initial begin
    #800000;
    miscompares++;
    complete_run;
  end

  initial begin
    int dv[3];
    dv = '{12, 4, 48};
    void'($urandom(41152));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, `TCPS_ADDR_T0LO, 0, 32'h0000_0000);
    apb(0, `TCPS_ADDR_T1LO, 0, 32'h0000_0000);
    apb(0, `TCPS_ADDR_CTRL, 0, 32'h0000_0000);
    $display("test reset done");
    d = $urandom;
    apb(1, `TCPS_ADDR_T0LO, d, 0);
    apb(0, `TCPS_ADDR_T0LO, 0, {24'h0, d[7:0]});
    check("t0_count_low", {24'h0, t0_count_low}, {24'h0, d[7:0]});
    apb(1, `TCPS_ADDR_T1LO, ~d, 0);
    apb(0, `TCPS_ADDR_T1LO, 0, {24'h0, ~d[7:0]});
    apb(1, `TCPS_ADDR_CTRL, d | 32'h0000_00c0, 0);
    apb(0, `TCPS_ADDR_CTRL, 0, d & 32'h0000_003f);
    apb(0, 12'h0a0, 0, 32'h0000_0000);
    @(posedge pclk);
    t0_inc <= 1;
    t1_inc <= 1;
    @(posedge pclk);
    t0_inc <= 0;
    t1_inc <= 0;
    @(posedge pclk);
    check("t1_count_low", {24'h0, t1_count_low},
          {24'h0, ~d[7:0] + 8'h01});
    check("t0_count_low", {24'h0, t0_count_low},
          {24'h0, d[7:0] + 8'h01});
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, `TCPS_ADDR_T0LO, 0, 32'h0000_0000);
    apb(0, `TCPS_ADDR_T1LO, 0, 32'h0000_0000);
    apb(0, `TCPS_ADDR_CTRL, 0, 32'h0000_0000);
    $display("test registers done");
    apb(1, `TCPS_ADDR_MODE, 0, 0);
    for (int c = 0; c < 3; c++) begin
      apb(1, `TCPS_ADDR_CTRL, c, 0);
      gap(3, dv[c], "t0 prescale");
      gap(2, dv[c], "t1 prescale");
    end
    apb(1, `TCPS_ADDR_CTRL, 32'h0000_0003, 0);
    gap(3, 48, "t0 external");
    $display("test prescale done");
    apb(1, `TCPS_ADDR_CTRL, 32'h0000_000c, 0);
    gap(3, 1, "t0 sysclk");
    gap(2, 1, "t1 sysclk");
    apb(1, `TCPS_ADDR_MODE, 32'h0000_0003, 0);
    gap(3, 5, "t0 counter");
    gap(2, 5, "t1 counter");
    $display("test select done");
    apb(1, `TCPS_ADDR_MODE, 0, 0);
    apb(1, `TCPS_ADDR_CTRL, 0, 0);
    gap(1, 5, "t2 low ext");
    apb(1, `TCPS_ADDR_CTRL, 32'h0000_0010, 0);
    gap(1, 1, "t2 low sys");
    gap(0, 1, "t2 high whole");
    apb(1, `TCPS_ADDR_MODE, 32'h0000_0008, 0);
    apb(1, `TCPS_ADDR_CTRL, 32'h0000_0020, 0);
    gap(0, 1, "t2 high sys");
    gap(1, 5, "t2 low split");
    apb(1, `TCPS_ADDR_CTRL, 32'h0000_0010, 0);
    gap(0, 5, "t2 high split ext");
    gap(1, 1, "t2 low split sys");
    apb(1, `TCPS_ADDR_MODE, 32'h0000_0004, 0);
    apb(1, `TCPS_ADDR_CTRL, 32'h0000_0001, 0);
    gap(1, 4, "t2 low prescale");
    $display("test timer2 done");
    complete_run;
  end
endmodule
`default_nettype wire
